// ---- rtl/core_regs_defines.svh ----
// Offsets, reset values and field positions of the core register block.
// Assumes inclusion by bare name from rtl files.
`ifndef CORE_REGS_DEFINES_SVH
`define CORE_REGS_DEFINES_SVH
`define ADDR_STACK_TOP_POINTER 8'h81
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_PRIMARY_ARITH 8'hE0
`define ADDR_SECONDARY_ARITH 8'hF0
`define RST_STACK_TOP_POINTER 8'h07
`define RST_DATA_POINTER 8'h00
`define RST_ARITH 8'h00
`define UPPER_HALF_BIT 7
`define UNUSED_OPCODE 8'hA5
`define NOP_OPCODE 8'h00
`define PAGE_LOCAL_BITS 11
`define BANK_BASE_SHIFT 3
`endif

// ---- rtl/core_regs_pkg.sv ----
// Types shared by the core register block.
// Assumes the defines header supplies all numbers.
package core_regs_pkg;
  typedef enum logic [2:0] {
    BR_NONE,
    BR_REL,
    BR_PAGE,
    BR_LONG,
    BR_INDIRECT
  } branch_kind_t;
  typedef enum logic [1:0] {
    STK_IDLE,
    STK_PUSH,
    STK_POP
  } stack_op_t;
endpackage

// ---- rtl/operand_decode.sv ----
// Combinational operand address decode: bank registers, indirect pointers, direct space.
// Assumes the bank select comes from the status word outside this block.
`include "core_regs_defines.svh"
module operand_decode (
  input wire logic [1:0] i_bank,       // Selected register bank
  input wire logic [2:0] i_reg_sel,    // Bank work register number
  input wire logic [7:0] i_direct,     // Direct operand address
  output logic [7:0] o_bank_addr,      // RAM address of bank register
  output logic [7:0] o_ind_ptr_addr,   // RAM address of pointer register
  output logic o_direct_is_periph      // Direct hits peripheral space
);
  always_comb begin
    o_bank_addr = {3'h0, i_bank, i_reg_sel};
    o_ind_ptr_addr = {3'h0, i_bank, 2'h0, i_reg_sel[0]};
    o_direct_is_periph = i_direct[`UPPER_HALF_BIT];
  end
endmodule // operand_decode

// ---- rtl/core_registers.sv ----
// Core architectural registers and operand/branch address forming.
// Assumes the sequencer issues single-cycle strobes and owns RAM timing.
//
// Summary of operation
// - Bank operand picks R0-R7 of bank.
// - Indirect operand uses R0 or R1 contents.
// - Relative target is next address plus offset.
// - Direct below 0x80 RAM, above peripherals.
// - Page jump replaces low eleven bits only.
// - Long jump loads whole target address.
// - Unused opcode executes as no-operation.
// - Pointer is high byte over low byte.
// - Pointer addresses flash and external RAM.
// - Stack pointer pre-increments on push.
// - Stack pointer resets to seven.
// - Primary accumulator at 0xE0, bit-addressable.
// - Secondary accumulator at 0xF0, bit-addressable.
// - Registers reachable on every peripheral page.
`include "core_regs_defines.svh"
module core_registers #(
  parameter int PC_WIDTH = 16
) (
  input wire logic i_clk,                    // System clock, 20 MHz
  input wire logic i_reset,                  // Synchronous reset, high
  input wire logic i_ce,                     // Clock enable
  input wire logic [7:0] i_opcode,           // Fetched opcode
  input wire logic [7:0] i_sfr_addr,         // Peripheral space address
  input wire logic i_sfr_wr,                 // Peripheral write strobe
  input wire logic i_sfr_rd,                 // Peripheral read strobe
  input wire logic [7:0] i_sfr_wdata,        // Peripheral write data
  input wire logic [2:0] i_sfr_bit,          // Bit number for bit ops
  input wire logic i_bit_wr,                 // Bit write strobe
  input wire logic i_bit_val,                // Bit write value
  input wire logic [3:0] i_sfr_page,         // Current page, ignored here
  input wire logic [1:0] i_bank,             // Register bank select
  input wire logic [2:0] i_reg_sel,          // Work register number
  input wire logic [7:0] i_direct,           // Direct operand
  input wire logic [7:0] i_ind_ptr_value,    // Value read from R0/R1
  input wire logic i_push,                   // Push strobe
  input wire logic i_pop,                    // Pop strobe
  input wire logic [15:0] i_next_pc,         // Address of next instruction
  input wire logic [7:0] i_rel,              // Relative offset
  input wire logic [10:0] i_page_local_target, // Eleven-bit target
  input wire logic [15:0] i_long_target,     // Sixteen-bit target
  input wire core_regs_pkg::branch_kind_t i_branch, // Branch kind
  output logic [7:0] o_sfr_rdata,            // Read data
  output logic o_sfr_hit,                    // Address owned by this block
  output logic [7:0] o_stack_addr,           // RAM address for stack access
  output logic o_stack_wr,                   // Push store strobe
  output logic [15:0] o_combined_data_pointer, // Flash/external RAM address
  output logic [15:0] o_branch_target,       // Formed branch target
  output logic o_branch_valid,               // Target valid
  output logic [7:0] o_bank_addr,            // Bank register RAM address
  output logic [7:0] o_ind_addr,             // Indirect RAM address
  output logic o_ind_ptr_periph,             // Pointer register in peripheral space
  output logic o_direct_periph,              // Direct in peripheral space
  output logic [7:0] o_exec_opcode,          // Opcode as executed
  output logic [7:0] o_primary_arith_reg,    // Accumulator
  output logic [7:0] o_secondary_arith_reg   // Second accumulator
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] stack_top_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] primary_arith_reg;
    logic [7:0] secondary_arith_reg;
    logic [7:0] rdata;
    logic hit;
    logic [7:0] stack_addr;
    logic stack_wr;
    logic [15:0] target;
    logic target_valid;
    logic [7:0] bank_addr;
    logic [7:0] ind_addr;
    logic direct_periph;
    logic ind_periph;
    logic [7:0] exec_opcode;
  } state_t;

  state_t q, d;
  logic [7:0] dec_bank_addr;
  logic [7:0] dec_ptr_addr;
  logic dec_periph;

  operand_decode u_dec (
    .i_bank(i_bank),
    .i_reg_sel(i_reg_sel),
    .i_direct(i_direct),
    .o_bank_addr(dec_bank_addr),
    .o_ind_ptr_addr(dec_ptr_addr),
    .o_direct_is_periph(dec_periph)
  );

  // Page input deliberately unused: these registers live on all pages
  function automatic logic owns_addr(input logic [7:0] a);
    owns_addr = (a == `ADDR_STACK_TOP_POINTER) || (a == `ADDR_DATA_POINTER_LOW) ||
                (a == `ADDR_DATA_POINTER_HIGH) || (a == `ADDR_PRIMARY_ARITH) ||
                (a == `ADDR_SECONDARY_ARITH);
  endfunction

  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] n, input logic b);
    logic [7:0] r;
    r = v;
    r[n] = b;
    set_bit = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.stack_wr = 1'b0;
    d.target_valid = 1'b0;
    d.hit = owns_addr(i_sfr_addr);
    // Read value sampled before any same-cycle write lands
    case (i_sfr_addr)
      `ADDR_STACK_TOP_POINTER: d.rdata = q.stack_top_pointer;
      `ADDR_DATA_POINTER_LOW: d.rdata = q.data_pointer_low;
      `ADDR_DATA_POINTER_HIGH: d.rdata = q.data_pointer_high;
      `ADDR_PRIMARY_ARITH: d.rdata = q.primary_arith_reg;
      `ADDR_SECONDARY_ARITH: d.rdata = q.secondary_arith_reg;
      default: d.rdata = 8'h00;
    endcase
    if (!i_sfr_rd) begin
      d.rdata = q.rdata;
    end
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        `ADDR_STACK_TOP_POINTER: d.stack_top_pointer = i_sfr_wdata;
        `ADDR_DATA_POINTER_LOW: d.data_pointer_low = i_sfr_wdata;
        `ADDR_DATA_POINTER_HIGH: d.data_pointer_high = i_sfr_wdata;
        `ADDR_PRIMARY_ARITH: d.primary_arith_reg = i_sfr_wdata;
        `ADDR_SECONDARY_ARITH: d.secondary_arith_reg = i_sfr_wdata;
        default: d.rdata = d.rdata;
      endcase
    end else if (i_bit_wr) begin
      // Only the two accumulators are bit-addressable
      case (i_sfr_addr)
        `ADDR_PRIMARY_ARITH: d.primary_arith_reg = set_bit(q.primary_arith_reg, i_sfr_bit, i_bit_val);
        `ADDR_SECONDARY_ARITH: d.secondary_arith_reg = set_bit(q.secondary_arith_reg, i_sfr_bit, i_bit_val);
        default: d.rdata = d.rdata;
      endcase
    end
    // Stack op outranks a register write to the pointer in the same cycle
    if (i_push) begin
      d.stack_top_pointer = q.stack_top_pointer + 8'h01;
      d.stack_addr = q.stack_top_pointer + 8'h01;
      d.stack_wr = 1'b1;
    end else if (i_pop) begin
      d.stack_addr = q.stack_top_pointer;
      d.stack_top_pointer = q.stack_top_pointer - 8'h01;
    end
    case (i_branch)
      core_regs_pkg::BR_REL: begin
        d.target = i_next_pc + {{8{i_rel[7]}}, i_rel};
        d.target_valid = 1'b1;
      end
      core_regs_pkg::BR_PAGE: begin
        d.target = {i_next_pc[PC_WIDTH-1:`PAGE_LOCAL_BITS], i_page_local_target};
        d.target_valid = 1'b1;
      end
      core_regs_pkg::BR_LONG: begin
        d.target = i_long_target;
        d.target_valid = 1'b1;
      end
      core_regs_pkg::BR_INDIRECT: begin
        d.target = {q.data_pointer_high, q.data_pointer_low} + {8'h00, q.primary_arith_reg};
        d.target_valid = 1'b1;
      end
      default: d.target = q.target;
    endcase
    d.bank_addr = dec_bank_addr;
    d.ind_addr = i_ind_ptr_value;
    d.ind_periph = dec_ptr_addr[`UPPER_HALF_BIT];
    d.direct_periph = dec_periph;
    d.exec_opcode = (i_opcode == `UNUSED_OPCODE) ? `NOP_OPCODE : i_opcode;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
      q.stack_top_pointer <= `RST_STACK_TOP_POINTER;
      q.data_pointer_low <= `RST_DATA_POINTER;
      q.data_pointer_high <= `RST_DATA_POINTER;
      q.primary_arith_reg <= `RST_ARITH;
      q.secondary_arith_reg <= `RST_ARITH;
    end else if (i_ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_sfr_rdata = q.rdata;
  assign o_sfr_hit = q.hit;
  assign o_stack_addr = q.stack_addr;
  assign o_stack_wr = q.stack_wr;
  assign o_combined_data_pointer = {q.data_pointer_high, q.data_pointer_low};
  assign o_branch_target = q.target;
  assign o_branch_valid = q.target_valid;
  assign o_bank_addr = q.bank_addr;
  assign o_ind_addr = q.ind_addr;
  assign o_ind_ptr_periph = q.ind_periph;
  assign o_direct_periph = q.direct_periph;
  assign o_exec_opcode = q.exec_opcode;
  assign o_primary_arith_reg = q.primary_arith_reg;
  assign o_secondary_arith_reg = q.secondary_arith_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_sp_reset;
    @(posedge i_clk) $past(i_reset) |-> q.stack_top_pointer == `RST_STACK_TOP_POINTER;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not seven after reset");

  property p_push;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_push) |=>
      (o_stack_wr && o_stack_addr == $past(q.stack_top_pointer) + 8'h01 && q.stack_top_pointer == o_stack_addr);
  endproperty
  a_push: assert property (p_push) else $error("push did not pre-increment");

  property p_pop;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_pop && !i_push) |=>
      (o_stack_addr == $past(q.stack_top_pointer) && q.stack_top_pointer == o_stack_addr - 8'h01);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not read then decrement");

  property p_rel;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_branch == core_regs_pkg::BR_REL) |=>
      o_branch_target == $past(i_next_pc) + {{8{$past(i_rel[7])}}, $past(i_rel)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");

  property p_page;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_branch == core_regs_pkg::BR_PAGE) |=>
      (o_branch_target[15:11] == $past(i_next_pc[15:11]) && o_branch_target[10:0] == $past(i_page_local_target));
  endproperty
  a_page: assert property (p_page) else $error("page target left its page");

  property p_long;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_branch == core_regs_pkg::BR_LONG) |=>
      (o_branch_valid && o_branch_target == $past(i_long_target));
  endproperty
  a_long: assert property (p_long) else $error("long target wrong");

  property p_nop;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_opcode == `UNUSED_OPCODE) |=> o_exec_opcode == `NOP_OPCODE;
  endproperty
  a_nop: assert property (p_nop) else $error("unused opcode not a no-op");

  property p_combined_data_pointer;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_sfr_wr && i_sfr_addr == `ADDR_DATA_POINTER_HIGH) |=> o_combined_data_pointer[15:8] == $past(i_sfr_wdata);
  endproperty
  a_combined_data_pointer: assert property (p_combined_data_pointer) else $error("pointer high byte misplaced");

  property p_acc_bit;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !i_sfr_wr && i_bit_wr && i_sfr_addr == `ADDR_PRIMARY_ARITH) |=>
      o_primary_arith_reg[$past(i_sfr_bit)] == $past(i_bit_val);
  endproperty
  a_acc_bit: assert property (p_acc_bit) else $error("accumulator bit write lost");

  property p_direct;
    @(posedge i_clk) disable iff (i_reset) i_ce |=> o_direct_periph == ($past(i_direct) >= 8'h80);
  endproperty
  a_direct: assert property (p_direct) else $error("direct space split wrong");

  property p_sec_bit;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && !i_sfr_wr && i_bit_wr && i_sfr_addr == `ADDR_SECONDARY_ARITH) |=>
      o_secondary_arith_reg[$past(i_sfr_bit)] == $past(i_bit_val);
  endproperty
  a_sec_bit: assert property (p_sec_bit) else $error("second accumulator bit write lost");

  property p_bank_addr;
    @(posedge i_clk) disable iff (i_reset) i_ce |=> o_bank_addr == {3'h0, $past(i_bank), $past(i_reg_sel)};
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("bank register address wrong");

  // Pointer registers are R0/R1 of the same bank as the bank operand
  property p_ptr_addr;
    @(posedge i_clk) dec_ptr_addr == {dec_bank_addr[7:3], 2'h0, dec_bank_addr[0]};
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer register outside bank");

  property p_ind_addr;
    @(posedge i_clk) disable iff (i_reset) i_ce |=> (o_ind_addr == $past(i_ind_ptr_value) && !o_ind_ptr_periph);
  endproperty
  a_ind_addr: assert property (p_ind_addr) else $error("indirect address not pointer contents");

  property p_sec_wr;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_sfr_wr && i_sfr_addr == `ADDR_SECONDARY_ARITH) |=> o_secondary_arith_reg == $past(i_sfr_wdata);
  endproperty
  a_sec_wr: assert property (p_sec_wr) else $error("second accumulator write lost");

  property p_acc_wr;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_sfr_wr && i_sfr_addr == `ADDR_PRIMARY_ARITH) |=> o_primary_arith_reg == $past(i_sfr_wdata);
  endproperty
  a_acc_wr: assert property (p_acc_wr) else $error("accumulator write lost");

  property p_sp_wr;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_sfr_wr && !i_push && !i_pop && i_sfr_addr == `ADDR_STACK_TOP_POINTER) |=>
      q.stack_top_pointer == $past(i_sfr_wdata);
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("stack pointer write lost");

  property p_valid_pulse;
    @(posedge i_clk) disable iff (i_reset) (i_ce && i_branch == core_regs_pkg::BR_NONE) |=> !o_branch_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("branch valid without branch");

  // Low enable must freeze every register, outputs included
  property p_ce_freeze;
    @(posedge i_clk) disable iff (i_reset) !i_ce |=> $stable(q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  property p_combined_data_pointer_low;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_sfr_wr && i_sfr_addr == `ADDR_DATA_POINTER_LOW) |=> o_combined_data_pointer[7:0] == $past(i_sfr_wdata);
  endproperty
  a_combined_data_pointer_low: assert property (p_combined_data_pointer_low) else $error("pointer low byte misplaced");

  property p_read_hold;
    @(posedge i_clk) disable iff (i_reset) (i_ce && !i_sfr_rd) |=> $stable(o_sfr_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved without read");

  property p_unowned;
    @(posedge i_clk) disable iff (i_reset)
      (i_ce && i_sfr_rd && !owns_addr(i_sfr_addr)) |=> (o_sfr_rdata == 8'h00 && !o_sfr_hit);
  endproperty
  a_unowned: assert property (p_unowned) else $error("foreign address answered");

  property p_stack_wr_pulse;
    @(posedge i_clk) disable iff (i_reset) (i_ce && !i_push) |=> !o_stack_wr;
  endproperty
  a_stack_wr_pulse: assert property (p_stack_wr_pulse) else $error("stack store without push");

  c_push: cover property (@(posedge i_clk) i_ce && i_push);
  c_pop: cover property (@(posedge i_clk) i_ce && i_pop);
  c_rel: cover property (@(posedge i_clk) i_ce && i_branch == core_regs_pkg::BR_REL && i_rel[7]);
  c_nop: cover property (@(posedge i_clk) i_ce && i_opcode == `UNUSED_OPCODE);

endmodule // core_registers

// ---- verification/seq_ram_model.sv ----
// Data RAM model on the sequencer side: stores pushed bytes, returns work register contents.
// Assumes the core drives the stack address and the store strobe from registers.
module seq_ram_model (
  input wire logic i_clk,              // System clock
  input wire logic [7:0] i_stack_addr, // Stack RAM address
  input wire logic i_stack_wr,         // Push store strobe
  input wire logic [7:0] i_wdata,      // Byte to store
  input wire logic [7:0] i_rd_addr,    // Work register address
  output logic [7:0] o_rd_data         // Work register contents
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  // Non-zero pattern so a stuck pointer path shows
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hC3;
    end
  end
  always @(posedge i_clk) begin
    if (i_stack_wr) begin
      mem[i_stack_addr] <= i_wdata;
    end
  end
  assign o_rd_data = mem[i_rd_addr]; // Pointer byte from R0/R1
endmodule // seq_ram_model

// ---- verification/core_registers_tb_top.sv ----
// Bench for core_registers: table of register accesses, then hand-written tests.
// Assumes seq_ram_model plays the sequencer's data RAM.
module core_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic h;} row_t;
  typedef struct packed {core_regs_pkg::branch_kind_t k; logic [7:0] r; logic [15:0] e;} br_t;
  logic i_clk = 0, i_reset = 1, i_ce = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_bit_wr = 0, i_bit_val = 0;
  logic i_push = 0, i_pop = 0;
  logic [7:0] i_opcode = 8'h00, i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_direct = 8'h00, i_rel = 8'h00;
  logic [7:0] i_ind_ptr_value, o_sfr_rdata, o_stack_addr, o_bank_addr, o_ind_addr, o_exec_opcode, o_acc, o_sec;
  logic [2:0] i_sfr_bit = 3'h0, i_reg_sel = 3'h0;
  logic [3:0] i_sfr_page = 4'h0;
  logic [1:0] i_bank = 2'h0;
  logic [15:0] i_next_pc = 16'h1FFF, i_long_target = 16'h1ABC, o_cdp, o_branch_target;
  logic [10:0] i_page_local_target = 11'h123;
  core_regs_pkg::branch_kind_t i_branch = core_regs_pkg::BR_NONE;
  logic o_sfr_hit, o_stack_wr, o_branch_valid, o_ind_ptr_periph, o_direct_periph;
  int error_cnt = 0, comparisons = 0;
  row_t rows [12] = '{'{0, 8'h81, 8'h00, 8'h07, 1}, '{1, 8'h83, 8'h12, 8'h00, 1}, '{1, 8'h82, 8'h34, 8'h00, 1},
    '{0, 8'h83, 8'h00, 8'h12, 1}, '{0, 8'h82, 8'h00, 8'h34, 1}, '{1, 8'hE0, 8'hA5, 8'h00, 1},
    '{0, 8'hE0, 8'h00, 8'hA5, 1}, '{1, 8'hF0, 8'h5A, 8'h00, 1}, '{0, 8'hF0, 8'h00, 8'h5A, 1},
    '{1, 8'h90, 8'h77, 8'h00, 0}, '{0, 8'h90, 8'h00, 8'h00, 0}, '{0, 8'h81, 8'h00, 8'h07, 1}};
  br_t brs [5] = '{'{core_regs_pkg::BR_REL, 8'h80, 16'h1F7F}, '{core_regs_pkg::BR_REL, 8'h7F, 16'h207E},
    '{core_regs_pkg::BR_PAGE, 8'h00, 16'h1923}, '{core_regs_pkg::BR_LONG, 8'h00, 16'h1ABC},
    '{core_regs_pkg::BR_INDIRECT, 8'h00, 16'h12D9}};

  always #25 i_clk = ~i_clk;

  core_registers #(.PC_WIDTH(16)) dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_opcode(i_opcode),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_bit(i_sfr_bit), .i_bit_wr(i_bit_wr), .i_bit_val(i_bit_val), .i_sfr_page(i_sfr_page),
    .i_bank(i_bank), .i_reg_sel(i_reg_sel), .i_direct(i_direct), .i_ind_ptr_value(i_ind_ptr_value),
    .i_push(i_push), .i_pop(i_pop), .i_next_pc(i_next_pc), .i_rel(i_rel),
    .i_page_local_target(i_page_local_target), .i_long_target(i_long_target), .i_branch(i_branch),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .o_stack_addr(o_stack_addr), .o_stack_wr(o_stack_wr),
    .o_combined_data_pointer(o_cdp), .o_branch_target(o_branch_target), .o_branch_valid(o_branch_valid),
    .o_bank_addr(o_bank_addr), .o_ind_addr(o_ind_addr), .o_ind_ptr_periph(o_ind_ptr_periph),
    .o_direct_periph(o_direct_periph), .o_exec_opcode(o_exec_opcode), .o_primary_arith_reg(o_acc),
    .o_secondary_arith_reg(o_sec));

  seq_ram_model m_ram (.i_clk(i_clk), .i_stack_addr(o_stack_addr), .i_stack_wr(o_stack_wr),
    .i_wdata(i_sfr_wdata), .i_rd_addr(o_bank_addr), .o_rd_data(i_ind_ptr_value));

  task chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task chk16(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Taking edge, then strobes drop so each is seen exactly once
  task go;
    @(posedge i_clk);
    i_sfr_wr <= 0;
    i_sfr_rd <= 0;
    i_bit_wr <= 0;
    i_push <= 0;
    i_pop <= 0;
    i_branch <= core_regs_pkg::BR_NONE;
    #1;
  endtask
  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 0;
    #1;
    chk8("acc_rst", 8'h00, o_acc);
    chk8("sec_rst", 8'h00, o_sec);
    chk16("combined_data_pointer_rst", 16'h0000, o_cdp);
    // Whole defined bytes only, no reserved bits set
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_sfr_page <= 4'(i);
      i_sfr_addr <= rows[i].a;
      i_sfr_wdata <= rows[i].d;
      i_sfr_wr <= rows[i].wr;
      i_sfr_rd <= !rows[i].wr;
      go();
      chk8("hit", {7'h00, rows[i].h}, {7'h00, o_sfr_hit});
      if (!rows[i].wr) chk8("rdata", rows[i].e, o_sfr_rdata);
    end
    chk16("combined_data_pointer", 16'h1234, o_cdp);
    foreach (brs[i]) begin
      @(posedge i_clk);
      i_branch <= brs[i].k;
      i_rel <= brs[i].r;
      go();
      chk16("target", brs[i].e, o_branch_target);
      chk8("bvalid", 8'h01, {7'h00, o_branch_valid});
    end
    @(posedge i_clk);
    i_sfr_wdata <= 8'h6B;
    i_push <= 1;
    go();
    chk8("push1", 8'h08, o_stack_addr);
    chk8("swr", 8'h01, {7'h00, o_stack_wr});
    i_push <= 1;
    go();
    chk8("push2", 8'h09, o_stack_addr);
    go();
    chk8("swr_end", 8'h00, {7'h00, o_stack_wr});
    chk8("ram8", 8'h6B, m_ram.mem[8]);
    i_pop <= 1;
    go();
    chk8("pop", 8'h09, o_stack_addr);
    i_sfr_addr <= 8'h81;
    i_sfr_rd <= 1;
    go();
    chk8("sp_pop", 8'h08, o_sfr_rdata);
    i_bank <= 2'h2;
    i_reg_sel <= 3'h5;
    i_direct <= 8'h7F;
    i_opcode <= 8'hA5;
    go();
    chk8("bank", 8'h15, o_bank_addr);
    chk8("dir7F", 8'h00, {7'h00, o_direct_periph});
    chk8("opA5", 8'h00, o_exec_opcode);
    i_bank <= 2'h0;
    i_reg_sel <= 3'h1;
    i_direct <= 8'h80;
    i_opcode <= 8'h3C;
    go();
    go();
    chk8("ind", 8'hC2, o_ind_addr);
    chk8("indper", 8'h00, {7'h00, o_ind_ptr_periph});
    chk8("dir80", 8'h01, {7'h00, o_direct_periph});
    chk8("op3C", 8'h3C, o_exec_opcode);
    i_sfr_addr <= 8'hF0;
    i_bit_wr <= 1;
    i_bit_val <= 1;
    go();
    chk8("bitF0", 8'h5B, o_sec);
    i_sfr_addr <= 8'h83;
    i_bit_wr <= 1;
    go();
    chk16("bit83", 16'h1234, o_cdp);
    i_sfr_addr <= 8'hE0;
    i_sfr_bit <= 3'h1;
    i_bit_wr <= 1;
    go();
    chk8("bitE0", 8'hA7, o_acc);
    i_ce <= 0;
    i_sfr_addr <= 8'hE0;
    i_sfr_wdata <= 8'h11;
    i_sfr_wr <= 1;
    go();
    chk8("ce_hold", 8'hA7, o_acc);
    i_ce <= 1;
    i_reset <= 1;
    go();
    i_reset <= 0;
    chk8("acc_rst2", 8'h00, o_acc);
    chk16("combined_data_pointer_rst2", 16'h0000, o_cdp);
    end_of_test();
  end
endmodule // core_registers_tb_top
